// File: inc/aeb_pkg.sv
// Constants, encodings and types shared by the external bus cycle engine.
// Assumes a core clock and a separate link clock that paces the bus.
package aeb_pkg;

   localparam int ADDR_W    = 24;
   localparam int DATA_W    = 16;
   localparam int OPND_W    = 32;
   localparam int FC_W      = 3;
   localparam int PIN_W     = 21;
   localparam int MON_CNT_W = 8;

   // Acknowledge pair, high bit first, as sampled (active low).
   localparam logic [1:0] ACK_WAIT   = 2'h3;
   localparam logic [1:0] ACK_PORT8  = 2'h2;
   localparam logic [1:0] ACK_PORT16 = 2'h1;
   localparam logic [1:0] ACK_RSVD   = 2'h0;

   // Byte-count code of the bytes still to move.
   localparam logic [1:0] SIZ_BYTE  = 2'h1;
   localparam logic [1:0] SIZ_WORD  = 2'h2;
   localparam logic [1:0] SIZ_3BYTE = 2'h3;
   localparam logic [1:0] SIZ_LONG  = 2'h0;

   localparam logic [2:0] CNT_BYTE = 3'h1;
   localparam logic [2:0] CNT_WORD = 3'h2;
   localparam logic [2:0] CNT_LONG = 3'h4;

   // Bus monitor: longest period in system clocks, two link states each.
   localparam logic [MON_CNT_W-1:0] MON_MAX_CLK    = 8'h40;
   localparam int                   HALVES_PER_CLK = 2;

   typedef enum logic [3:0] {
      ST_IDLE, ST_S0, ST_S1, ST_S2, ST_W1, ST_W2,
      ST_S3, ST_S4, ST_S5, ST_HALT
   } aeb_state_t;

   typedef enum logic [1:0] {
      TERM_ACK, TERM_VECTOR_SELF_GENERATE, TERM_FAULT, TERM_RETRY
   } aeb_term_t;

endpackage

// File: rtl/aeb_sync.sv
// Two flip-flop synchroniser for levels and toggles.
// Assumes the input is stable in the source domain between changes.
`timescale 1ns/1ps
module aeb_sync #(
   parameter int W = 1
) (
   // Destination clock and reset.
   input  wire logic         clk,
   input  wire logic         rst,
   // Level in, resolved level out.
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] hold_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         hold_r <= '0;
      end else begin
         meta_r <= d;
         hold_r <= meta_r;
      end
   end

   assign q = hold_r;
endmodule

// File: rtl/aeb_monitor.sv
// Bus monitor counting link states while the address strobe is asserted.
// Assumes the period field is already synchronised to the link clock.
`timescale 1ns/1ps
module aeb_monitor
   import aeb_pkg::*;
(
   // Link clock and reset.
   input  wire logic       clk,
   input  wire logic       rst,
   // Cycle in progress and period select.
   input  wire logic       active,
   input  wire logic [1:0] monitor_period_field,
   // Response time exceeded.
   output logic            timeout
);
   logic [MON_CNT_W-1:0] cnt_r;
   logic [MON_CNT_W-1:0] limit;
   logic                 timeout_r;

   // Period halves with each field step; the monitor has no off switch.
   assign limit = MON_CNT_W'((MON_MAX_CLK >> monitor_period_field)
                             * HALVES_PER_CLK);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (active && cnt_r != limit) begin
         cnt_r <= cnt_r + MON_CNT_W'(1);
      end else if (!active) begin
         cnt_r <= '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timeout_r <= 1'b0;
      end else begin
         timeout_r <= active && (cnt_r >= limit - MON_CNT_W'(1));
      end
   end

   assign timeout = timeout_r;
endmodule

// File: rtl/aeb_ctrl.sv
// Asynchronous external bus cycle engine with dynamic port sizing.
// Assumes requests on core_clk; the bus is paced by link_clk, two link
// states making one period of the system clock output.
// Functional notes
// [R1] Drive a three-bit function code selecting one of eight spaces.
// [R2] On reads the width acknowledge ends the cycle and data is captured.
// [R3] On writes the acknowledge means data stored; the cycle then ends.
// [R4] Fault alone or with an acknowledge ends the cycle as a bus error.
// [R5] An outside bus master drives its own fault pin.
// [R6] Single-cycle request halts between cycles; with fault it means retry. Code halts only within a split operand, not after its last cycle.
// [R7] Self-vector input ends an interrupt acknowledge without bus data.
// [R8] An access takes at least three system clocks.
// [R9] Address and byte-count code start each transfer for lane decode.
// [R10] The peripheral moves data once strobes are valid, then acknowledges.
// [R11] Whole-clock wait states are added until an acknowledge is low.
// [R12] Internal monitor faults after a period of at most 64 clocks.
// [R13] Outside logic should fault accesses nobody answers.
// [R14] Inputs are sampled at the falling output clock and resolved first.
// [R15] Read data is taken one falling edge after the acknowledge.
// [R16] An acknowledge at state 2 gives a three-clock cycle.
// [R17] Operands are split into cycles for 8-bit and 16-bit ports.
// [R18] Acknowledge 11 waits, 10 is 8-bit, 01 and 00 are 16-bit.
// [R19] Byte-count code 01,10,11,00 shows the bytes still remaining.
// [R20] Strobe follows cycle start by half a clock; direction is stable.
// [R21] Strobes negate after termination before any following cycle.
`timescale 1ns/1ps
module aeb_ctrl
   import aeb_pkg::*;
(
   // Clocks and reset.
   input  wire logic                         core_clk,
   input  wire logic                         link_clk,
   input  wire logic                         sys_rst,
   // Core request.
   input  wire logic                         req_valid,
   output logic                              req_ready,
   input  wire logic                         req_write,
   input  wire logic                         req_iack,
   input  wire logic [aeb_pkg::FC_W-1:0]     req_fc,
   input  wire logic [aeb_pkg::ADDR_W-1:0]   req_addr,
   input  wire logic [1:0]                   req_size,
   input  wire logic [aeb_pkg::OPND_W-1:0]   req_wdata,
   input  wire logic [1:0]                   monitor_period_field,
   // Core response.
   output logic                              rsp_valid,
   output logic      [aeb_pkg::OPND_W-1:0]   rsp_rdata,
   output logic                              rsp_fault,
   output logic                              rsp_autovec,
   // Bus outputs.
   output logic                              system_clock_output,
   output logic      [aeb_pkg::ADDR_W-1:0]   address_out,
   output logic      [1:0]                   size_code,
   output logic      [aeb_pkg::FC_W-1:0]     function_code,
   output logic                              read_write,
   output logic                              address_strobe_n,
   output logic                              data_strobe_n,
   // Data bus pins.
   input  wire logic [aeb_pkg::DATA_W-1:0]   data_in,
   output logic      [aeb_pkg::DATA_W-1:0]   data_out,
   output logic                              data_oe_n,
   // Bus inputs.
   input  wire logic [1:0]                   port_width_ack_n,
   input  wire logic                         bus_fault_n,
   input  wire logic                         single_cycle_n,
   input  wire logic                         vector_self_generate_n
);
   import aeb_pkg::*;

   function automatic logic [2:0] siz_to_cnt(input logic [1:0] siz);
      siz_to_cnt = (siz == SIZ_LONG) ? CNT_LONG : {1'b0, siz};
   endfunction

   function automatic logic [2:0] xfer_bytes(input logic [2:0] cnt,
                                             input logic a0,
                                             input logic p8);
      xfer_bytes = (p8 || a0 || cnt == CNT_BYTE) ? CNT_BYTE : CNT_WORD;
   endfunction

   function automatic logic [DATA_W-1:0] wr_lanes(input logic [31:0] wb,
                                                  input logic a0,
                                                  input logic [2:0] cnt);
      wr_lanes = (!a0 && cnt >= CNT_WORD) ? wb[31:16]
                                          : {wb[31:24], wb[31:24]};
   endfunction

   // Core domain registers.
   logic                busy_r;
   logic                ready_r;
   logic                req_tgl_r;
   logic                p_write_r;
   logic                p_iack_r;
   logic [FC_W-1:0]     p_fc_r;
   logic [ADDR_W-1:0]   p_addr_r;
   logic [1:0]          p_size_r;
   logic [OPND_W-1:0]   p_wdata_r;
   logic                done_s;
   logic                done_seen_r;
   logic                done_evt;
   logic                rsp_valid_r;
   logic [OPND_W-1:0]   rsp_rdata_r;
   logic                rsp_fault_r;
   logic                rsp_vector_self_generate_r;
   // Link domain registers.
   aeb_state_t          state_r;
   aeb_state_t          state_nxt;
   aeb_term_t           term_r;
   logic                ph_r;
   logic                req_s;
   logic                req_seen_r;
   logic                done_tgl_r;
   logic [PIN_W-1:0]    pin_s;
   logic [1:0]          mon_fld_s;
   logic                mon_to;
   logic [2:0]          cnt_r;
   logic [2:0]          cnt_nxt;
   logic [ADDR_W-1:0]   addr_r;
   logic [ADDR_W-1:0]   addr_nxt;
   logic [OPND_W-1:0]   wbuf_r;
   logic [OPND_W-1:0]   wbuf_nxt;
   logic [OPND_W-1:0]   rdacc_r;
   logic                port8_r;
   logic                res_fault_r;
   logic                res_vector_self_generate_r;
   logic [ADDR_W-1:0]   addr_out_r;
   logic [1:0]          siz_r;
   logic [FC_W-1:0]     fc_r;
   logic                rw_r;
   logic                as_n_r;
   logic                ds_n_r;
   logic [DATA_W-1:0]   dout_r;
   logic                oe_n_r;
   // Link domain decode.
   logic [1:0]          ack_s;
   logic                fault_s;
   logic                halt_s;
   logic                vector_self_generate_s;
   logic [DATA_W-1:0]   din_s;
   logic                start;
   logic                sample;
   logic                ack_hit;
   logic                vector_self_generate_hit;
   logic                term_now;
   logic [2:0]          nb;
   logic                last;

   // Request capture and toggle toward the link.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_r    <= 1'b0;
         ready_r   <= 1'b1;
         req_tgl_r <= 1'b0;
         p_write_r <= 1'b0;
         p_iack_r  <= 1'b0;
         p_fc_r    <= '0;
         p_addr_r  <= '0;
         p_size_r  <= SIZ_BYTE;
         p_wdata_r <= '0;
      end else if (req_valid && ready_r) begin
         busy_r    <= 1'b1;
         ready_r   <= 1'b0;
         req_tgl_r <= ~req_tgl_r;
         p_write_r <= req_write;
         p_iack_r  <= req_iack;
         p_fc_r    <= req_fc;
         p_addr_r  <= req_addr;
         p_size_r  <= req_size;
         p_wdata_r <= req_wdata;
      end else if (done_evt) begin
         busy_r  <= 1'b0;
         ready_r <= 1'b1;
      end
   end

   aeb_sync #(.W(1)) u_done_sync (
      .clk (core_clk),
      .rst (sys_rst),
      .d   (done_tgl_r),
      .q   (done_s)
   );

   assign done_evt = done_s ^ done_seen_r;

   // Response pulse; link results are held until the next response.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         done_seen_r <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= '0;
         rsp_fault_r <= 1'b0;
         rsp_vector_self_generate_r  <= 1'b0;
      end else begin
         done_seen_r <= done_s;
         rsp_valid_r <= done_evt && busy_r;
         if (done_evt) begin
            rsp_rdata_r <= rdacc_r;
            rsp_fault_r <= res_fault_r;
            rsp_vector_self_generate_r  <= res_vector_self_generate_r;
         end
      end
   end

   // [R14] resolved pin sampling.
   aeb_sync #(.W(PIN_W)) u_pin_sync (
      .clk (link_clk),
      .rst (sys_rst),
      .d   ({port_width_ack_n, bus_fault_n, single_cycle_n,
             vector_self_generate_n, data_in}),
      .q   (pin_s)
   );

   aeb_sync #(.W(1)) u_req_sync (
      .clk (link_clk),
      .rst (sys_rst),
      .d   (req_tgl_r),
      .q   (req_s)
   );

   aeb_sync #(.W(2)) u_mon_sync (
      .clk (link_clk),
      .rst (sys_rst),
      .d   (monitor_period_field),
      .q   (mon_fld_s)
   );

   // [R12] internal bus monitor.
   aeb_monitor u_monitor (
      .clk                  (link_clk),
      .rst                  (sys_rst),
      .active               (!as_n_r),
      .monitor_period_field (mon_fld_s),
      .timeout              (mon_to)
   );

   assign ack_s    = pin_s[20:19];
   assign fault_s  = !pin_s[18];
   assign halt_s   = !pin_s[17];
   assign vector_self_generate_s   = !pin_s[16];
   assign din_s    = pin_s[15:0];
   // [R14] sample at falling edge.
   assign sample   = (state_r == ST_S2) || (state_r == ST_W2);
   assign start    = (state_r == ST_IDLE) && (req_s ^ req_seen_r) && !ph_r;
   // [R18] acknowledge decode.
   assign ack_hit  = ack_s != ACK_WAIT;
   // [R7] self-vector termination.
   assign vector_self_generate_hit = p_iack_r && vector_self_generate_s;
   assign term_now = fault_s || mon_to || ack_hit || vector_self_generate_hit;
   assign nb       = xfer_bytes(cnt_r, addr_r[0], port8_r);
   assign last     = (term_r != TERM_ACK) || (cnt_r == nb);

   // System clock output; even states are its high phase.
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ph_r <= 1'b0;
      end else begin
         ph_r <= ~ph_r;
      end
   end

   // [R11] wait states until acknowledge.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (start) state_nxt = ST_S0;
         ST_S0:   state_nxt = ST_S1;
         ST_S1:   state_nxt = ST_S2;
         ST_S2,
         ST_W2:   state_nxt = term_now ? ST_S3 : ST_W1;
         ST_W1:   state_nxt = ST_W2;
         ST_S3:   state_nxt = ST_S4;
         ST_S4:   state_nxt = ST_S5;
         ST_S5: begin
            if (term_r == TERM_RETRY || (!last && halt_s)) begin
               state_nxt = ST_HALT;
            end else if (last) begin
               state_nxt = ST_IDLE;
            end else begin
               state_nxt = ST_S0;
            end
         end
         ST_HALT: if (!halt_s && !ph_r) state_nxt = ST_S0;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // [R4] fault wins over acknowledge.
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         term_r  <= TERM_ACK;
         port8_r <= 1'b0;
      end else if (sample && term_now) begin
         port8_r <= ack_s == ACK_PORT8;
         if (fault_s && halt_s) begin
            term_r <= TERM_RETRY;
         end else if (fault_s || mon_to) begin
            term_r <= TERM_FAULT;
         end else if (vector_self_generate_hit) begin
            term_r <= TERM_VECTOR_SELF_GENERATE;
         end else begin
            term_r <= TERM_ACK;
         end
      end
   end

   // [R17] operand split across cycles.
   always_comb begin
      cnt_nxt  = cnt_r;
      addr_nxt = addr_r;
      wbuf_nxt = wbuf_r;
      if (start) begin
         cnt_nxt  = siz_to_cnt(p_size_r);
         addr_nxt = p_addr_r;
         wbuf_nxt = p_wdata_r << {CNT_LONG - cnt_nxt, 3'h0};
      end else if (state_r == ST_S5 && term_r == TERM_ACK && !last) begin
         cnt_nxt  = cnt_r - nb;
         addr_nxt = addr_r + ADDR_W'(nb);
         wbuf_nxt = wbuf_r << {nb, 3'h0};
      end
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r  <= CNT_BYTE;
         addr_r <= '0;
         wbuf_r <= '0;
      end else begin
         cnt_r  <= cnt_nxt;
         addr_r <= addr_nxt;
         wbuf_r <= wbuf_nxt;
      end
   end

   // [R15] read capture one falling edge on.
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdacc_r <= '0;
      end else if (start) begin
         rdacc_r <= '0;
      end else if (state_r == ST_S4 && term_r == TERM_ACK && !p_write_r) begin
         if (nb == CNT_WORD) begin
            rdacc_r <= {rdacc_r[15:0], din_s};
         end else if (port8_r || !addr_r[0]) begin
            rdacc_r <= {rdacc_r[23:0], din_s[15:8]};
         end else begin
            rdacc_r <= {rdacc_r[23:0], din_s[7:0]};
         end
      end
   end

   // Handshake toward the core domain.
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req_seen_r  <= 1'b0;
         done_tgl_r  <= 1'b0;
         res_fault_r <= 1'b0;
         res_vector_self_generate_r  <= 1'b0;
      end else if (start) begin
         req_seen_r <= req_s;
      end else if (state_r == ST_S5 && state_nxt == ST_IDLE) begin
         done_tgl_r  <= ~done_tgl_r;
         res_fault_r <= term_r == TERM_FAULT;
         res_vector_self_generate_r  <= term_r == TERM_VECTOR_SELF_GENERATE;
      end
   end

   // [R9] address, code and direction at cycle start.
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_out_r <= '0;
         siz_r      <= SIZ_BYTE;
         fc_r       <= '0;
         rw_r       <= 1'b1;
         dout_r     <= '0;
      end else if (state_nxt == ST_S0) begin
         addr_out_r <= addr_nxt;
         siz_r      <= cnt_nxt[1:0];
         fc_r       <= p_fc_r;
         rw_r       <= !p_write_r;
         dout_r     <= wr_lanes(wbuf_nxt, addr_nxt[0], cnt_nxt);
      end
   end

   // [R21] strobes negate before the next cycle.
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         as_n_r <= 1'b1;
         ds_n_r <= 1'b1;
         oe_n_r <= 1'b1;
      end else begin
         as_n_r <= !(state_nxt inside {ST_S1, ST_S2, ST_W1, ST_W2,
                                       ST_S3, ST_S4});
         // [R3] write strobe timing.
         ds_n_r <= p_write_r ? !(state_nxt inside {ST_W1, ST_W2, ST_S3, ST_S4})
                             : !(state_nxt inside {ST_S1, ST_S2, ST_W1,
                                                   ST_W2, ST_S3, ST_S4});
         oe_n_r <= !(p_write_r && state_nxt inside {ST_S2, ST_W1, ST_W2,
                                                    ST_S3, ST_S4, ST_S5});
      end
   end

   assign req_ready           = ready_r;
   assign rsp_valid           = rsp_valid_r;
   assign rsp_rdata           = rsp_rdata_r;
   assign rsp_fault           = rsp_fault_r;
   assign rsp_autovec         = rsp_vector_self_generate_r;
   assign system_clock_output = ph_r;
   assign address_out         = addr_out_r;
   assign size_code           = siz_r;
   assign function_code       = fc_r;
   assign read_write          = rw_r;
   assign address_strobe_n    = as_n_r;
   assign data_strobe_n       = ds_n_r;
   assign data_out            = dout_r;
   assign data_oe_n           = oe_n_r;

   sequence seq_fast_tail;
      (state_r == ST_S3) ##1 (state_r == ST_S4) ##1 address_strobe_n;
   endsequence

   sequence seq_strobe_low;
      !address_strobe_n [*4];
   endsequence

   AST_FC_STABLE: assert property ( // [R1]
      @(posedge link_clk) disable iff (sys_rst)
      (!address_strobe_n && $past(!address_strobe_n)) |->
         $stable(function_code) && $stable(read_write))
      else $error("Function code or direction moved under strobe.");

   AST_READ_LATCH: assert property ( // [R2]
      @(posedge link_clk) disable iff (sys_rst)
      (state_r == ST_S4 && term_r == TERM_ACK && !p_write_r
       && nb == CNT_WORD) |=> rdacc_r[15:0] == $past(din_s))
      else $error("Read word not captured after acknowledge.");

   AST_FAULT: assert property ( // [R4]
      @(posedge link_clk) disable iff (sys_rst)
      (sample && fault_s && !halt_s) |=> term_r == TERM_FAULT)
      else $error("Fault input not taken as bus error.");

   AST_RETRY: assert property ( // [R6]
      @(posedge link_clk) disable iff (sys_rst)
      (sample && fault_s && halt_s) |=> ##3 state_r == ST_HALT)
      else $error("Fault with halt did not end in retry hold.");

   AST_VECTOR_SELF_GENERATE: assert property ( // [R7]
      @(posedge link_clk) disable iff (sys_rst)
      (sample && vector_self_generate_hit && !fault_s && !mon_to) |=> term_r == TERM_VECTOR_SELF_GENERATE)
      else $error("Self-vector input did not end the acknowledge cycle.");

   AST_MIN_CYCLE: assert property ( // [R8]
      @(posedge link_clk) disable iff (sys_rst)
      $fell(address_strobe_n) |-> seq_strobe_low)
      else $error("Access shorter than three clocks.");

   AST_WAIT: assert property ( // [R11]
      @(posedge link_clk) disable iff (sys_rst)
      (sample && !term_now) |=> state_r == ST_W1 ##1 state_r == ST_W2)
      else $error("No whole-clock wait without acknowledge.");

   AST_TIMEOUT: assert property ( // [R12]
      @(posedge link_clk) disable iff (sys_rst)
      (sample && mon_to) |=> term_r inside {TERM_FAULT, TERM_RETRY})
      else $error("Monitor time-out did not fault the cycle.");

   AST_NO_WAIT: assert property ( // [R16]
      @(posedge link_clk) disable iff (sys_rst)
      (state_r == ST_S2 && term_now) |=> seq_fast_tail)
      else $error("Acknowledge at state 2 still inserted waits.");

   AST_SIZE: assert property ( // [R19]
      @(posedge link_clk) disable iff (sys_rst)
      (state_r == ST_S0) |-> size_code == cnt_r[1:0] && cnt_r != 3'h0)
      else $error("Byte-count code does not match bytes remaining.");

   AST_AS_HALF: assert property ( // [R20]
      @(posedge link_clk) disable iff (sys_rst)
      (state_r == ST_S0) |-> address_strobe_n ##1 !address_strobe_n)
      else $error("Address strobe not half a clock after start.");

   AST_STROBES_OFF: assert property ( // [R21]
      @(posedge link_clk) disable iff (sys_rst)
      (state_r == ST_S5) |-> address_strobe_n && data_strobe_n)
      else $error("Strobes still asserted after termination.");

endmodule

// File: testbench/aeb_partner.sv
// Behavioural peripheral on the parallel bus for the cycle engine.
// Assumes the bench sets the answer mode between operands.
`timescale 1ns/1ps
module aeb_partner
   import aeb_pkg::*;
(
   // Link clock and bench controls.
   input  wire logic        link_clk,
   input  wire logic [1:0]  ack_code,
   input  wire logic [7:0]  dly,
   input  wire logic        fault_en,
   input  wire logic        vector_self_generate_en,
   input  wire logic        halt_en,
   // Bus from the device.
   input  wire logic        system_clock_output,
   input  wire logic [23:0] address_out,
   input  wire logic [1:0]  size_code,
   input  wire logic [2:0]  function_code,
   input  wire logic        read_write,
   input  wire logic        address_strobe_n,
   input  wire logic        data_strobe_n,
   input  wire logic [15:0] data_out,
   input  wire logic        data_oe_n,
   // Bus to the device.
   output logic [15:0]      data_in,
   output logic [1:0]       port_width_ack_n,
   output logic             bus_fault_n,
   output logic             single_cycle_n,
   output logic             vector_self_generate_n,
   // Observations.
   output int               n_as,
   output logic [15:0]      last_wr,
   output logic [2:0]       last_fc,
   output logic [1:0]       last_sz,
   output logic             last_ck,
   output logic [7:0]       last_len
);
   logic [7:0] cnt_r = 8'h00;
   logic       as_q = 1'b1;
   logic       hit;
   initial begin
      n_as = 0;
      data_in = 16'h0000;
   end
   assign hit = !address_strobe_n && cnt_r >= dly;
   assign port_width_ack_n = hit ? ack_code : 2'h3;
   assign bus_fault_n = !(hit && fault_en);
   assign vector_self_generate_n = !(hit && vector_self_generate_en);
   assign single_cycle_n = !(hit && halt_en);
   always @(posedge link_clk) begin
      as_q <= address_strobe_n;
      cnt_r <= address_strobe_n ? 8'h00 : cnt_r + 8'h01;
      if (as_q && !address_strobe_n) begin
         n_as <= n_as + 1;
         last_fc <= function_code;
         last_sz <= size_code;
         last_ck <= system_clock_output;
      end
      if (!as_q && address_strobe_n) begin
         last_len <= cnt_r;
      end
      if (!address_strobe_n) begin
         data_in <= {address_out[7:0] ^ 8'hA5, address_out[7:0]};
      end else begin
         data_in <= ~data_in;
      end
      if (!data_strobe_n && !read_write && !data_oe_n) begin
         last_wr <= data_out;
      end
   end
endmodule

// File: testbench/test_async_external_bus_cycle_control.sv
// Self-checking bench for the external bus cycle engine.
// Assumes the partner model sits on the link side.
`timescale 1ns/1ps
module test_async_external_bus_cycle_control;
   import aeb_pkg::*;
   logic core_clk = 0, link_clk = 0, sys_rst = 1;
   logic req_valid = 0, req_write = 0, req_iack = 0;
   logic [2:0] req_fc = 0;
   logic [23:0] req_addr = 0;
   logic [1:0] req_size = 0, monitor_period_field = 0, ack_code = 1;
   logic [31:0] req_wdata = 0, rsp_rdata;
   logic [7:0] dly = 0, last_len;
   logic fault_en = 0, vector_self_generate_en = 0, req_ready, rsp_valid, rsp_fault;
   logic rsp_autovec, system_clock_output, read_write, data_oe_n;
   logic address_strobe_n, data_strobe_n, bus_fault_n, single_cycle_n;
   logic vector_self_generate_n, last_ck, halt_en = 0;
   logic [23:0] address_out;
   logic [1:0] size_code, port_width_ack_n, last_sz;
   logic [2:0] function_code, last_fc;
   logic [15:0] data_in, data_out, last_wr;
   int n_as, errors = 0, cmp_count = 0, n0;
   aeb_ctrl dut_u (.*);
   aeb_partner peer_u (.*);
   initial forever #2.5 core_clk = ~core_clk;
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic op(logic w, i, logic [2:0] f, logic [23:0] a,
                     logic [1:0] s, logic [31:0] d);
      int k;
      while (req_ready !== 1'b1) @(negedge core_clk);
      {req_write, req_iack, req_fc, req_addr} = {w, i, f, a};
      {req_size, req_wdata, req_valid} = {s, d, 1'b1};
      n0 = n_as;
      @(negedge core_clk);
      req_valid = 0;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 3000) begin
         @(negedge core_clk);
         k++;
      end
      if (k == 3000) chk("rsp_valid", 1, 0);
   endtask
   task automatic t_fc;
      for (int f = 0; f < 8; f++) begin
         ack_code = f[0] ? 2'h0 : 2'h1;
         op(0, 0, f[2:0], 24'(f * 2), SIZ_WORD, 0);
         chk("fc", f, last_fc);
         chk("rdata", {8'(f * 2) ^ 8'hA5, 8'(f * 2)}, rsp_rdata[15:0]);
         chk("as_len", 1, last_len >= 4);
         chk("clk_at_strobe", 0, last_ck);
      end
   endtask
   task automatic t_long;
      ack_code = 2'h1;
      op(0, 0, 3'h5, 24'h100, SIZ_LONG, 0);
      chk("rdata", 32'hA500A702, rsp_rdata);
      chk("cycles", 2, n_as - n0);
      chk("size", SIZ_WORD, last_sz);
      chk("fault", 0, rsp_fault);
      halt_en = 1;
      op(0, 0, 3'h5, 24'h100, SIZ_LONG, 0);
      chk("rdata_halt", 32'hA500A702, rsp_rdata);
      chk("cycles_halt", 2, n_as - n0);
      halt_en = 0;
   endtask
   task automatic t_wr8;
      ack_code = 2'h2;
      op(1, 0, 3'h1, 24'h20, SIZ_WORD, 32'h1234);
      chk("cycles", 2, n_as - n0);
      chk("wdata", 8'h34, last_wr[15:8]);
      chk("size", SIZ_BYTE, last_sz);
   endtask
   task automatic t_term;
      {ack_code, fault_en, dly} = {2'h3, 1'b1, 8'h02};
      op(0, 0, 3'h2, 24'h40, SIZ_WORD, 0);
      chk("fault", 1, rsp_fault);
      {fault_en, monitor_period_field} = {1'b0, 2'h3};
      op(0, 0, 3'h2, 24'h42, SIZ_WORD, 0);
      chk("timeout", 1, rsp_fault);
      vector_self_generate_en = 1;
      op(0, 1, 3'h7, 24'h0E, SIZ_BYTE, 0);
      chk("autovec", 1, rsp_autovec);
      vector_self_generate_en = 0;
   endtask
   task automatic tally_and_finish;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #60000;
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (5) @(negedge core_clk);
      sys_rst = 0;
      t_fc();
      t_long();
      t_wr8();
      t_term();
      tally_and_finish();
   end
endmodule
